// ### inc/cic_pkg.sv
`default_nettype none
package cic_pkg;

    localparam int unsigned NUM_SRC = 19;

    // Register indices; byte address on the bus is four times the index
    localparam logic [7:0] IDX_TIMER_CTRL  = 8'h80;
    localparam logic [7:0] IDX_EXT_FLAGS_A = 8'h91;
    localparam logic [7:0] IDX_BASE_EN     = 8'ha8;
    localparam logic [7:0] IDX_BASE_LVL    = 8'hb8;
    localparam logic [7:0] IDX_EXT_FLAGS_B = 8'hd8;
    localparam logic [7:0] IDX_EXT_EN_A    = 8'he8;
    localparam logic [7:0] IDX_EXT_EN_B    = 8'he9;
    localparam logic [7:0] IDX_EXT_LVL_A   = 8'hf8;
    localparam logic [7:0] IDX_EXT_LVL_B   = 8'hf9;

    // Writable-bit masks
    localparam logic [7:0] MASK_BASE_EN    = 8'hdf;
    localparam logic [7:0] MASK_BASE_LVL   = 8'h5f;
    localparam logic [4:0] MASK_EXT_B      = 5'h1f;

    localparam logic [7:0] RST_REG8        = 8'h00;
    localparam logic [4:0] RST_REG5        = 5'h00;

    // Base enable fields
    localparam int unsigned BIT_GLOBAL_GATE = 7;
    localparam int unsigned BIT_SERIAL1_EN  = 6;
    localparam int unsigned BIT_SERIAL0_EN  = 4;
    localparam int unsigned BIT_TIMER1_EN   = 3;
    localparam int unsigned BIT_EXT_IN1_EN  = 2;
    localparam int unsigned BIT_TIMER0_EN   = 1;
    localparam int unsigned BIT_EXT_IN0_EN  = 0;

    // Timer control flag positions
    localparam int unsigned BIT_EXT_IN0_PEND = 1;
    localparam int unsigned BIT_EXT_IN1_PEND = 3;
    localparam int unsigned BIT_TIMER0_PEND  = 5;
    localparam int unsigned BIT_TIMER1_PEND  = 7;

    // Extended flag positions
    localparam int unsigned BIT_TIMER3_PEND  = 7;
    localparam int unsigned BIT_CIPHER_PEND  = 6;
    localparam int unsigned BIT_TIMER2_PEND  = 5;
    localparam int unsigned BIT_SLEEP_PEND   = 1;
    localparam int unsigned BIT_WAKEUP_PEND  = 0;

    // General-purpose pins; two of them double as external inputs
    localparam int unsigned NUM_GPIO      = 22;
    localparam int unsigned GPIO_EXT0_PIN = 18;
    localparam int unsigned GPIO_EXT1_PIN = 19;
    localparam logic [21:0] GPIO_EXT_MASK = 22'h0c0000;

    localparam int unsigned NUM_VOICE = 24;

    localparam logic [15:0] VEC_BASE   = 16'h0003;
    localparam logic [15:0] VEC_STRIDE = 16'h0008;

endpackage : cic_pkg
`default_nettype wire

// ### hdl/cic_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Nineteen sources 0..18, source n vectors to 0x0003 plus eight times n.
// - Grant sends CPU to source vector; return resumes interrupted code.
// - Same-level simultaneous requests served lowest source number first.
// - Acknowledge only with global gate and own enable both set.
// - Base enable register layout; bit 5 reserved, resets zero.
// - First extended enable register holds eight enables, reset zero.
// - Second extended enable register holds five enables; upper bits read zero.
// - Hardware sets extended flag on trigger; reads one while pending.
// - First extended flags at bits 7..5, low bits zero, write one clears.
// - Second extended flags: sleep timeout bit 1, wake-up bit 0, write one clears.
// - Every source has a flag; some are cleared by hardware on grant.
// - External and timer flags in timer control bits 1,3,5,7; externals wake.
// - Normal-mode GPIO source takes all pins except the external inputs.
// - Serial request is cause register bit 0; bits 3:1 give cause.
// - SPI requests only with local and controller enables; local flag requests.
// - Voice requests when any of 24 sub-sources has enable and flag.
// - Each source has one level bit in base or extended level registers.
// - Enables change any time and apply to the next arbitration.
// - Low service preempted only by high; high never preempted.
module cic_ctrl (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        power_down,
    input  wire logic        ext_in0_evt,
    input  wire logic        ext_in1_evt,
    input  wire logic        timer0_evt,
    input  wire logic        timer1_evt,
    input  wire logic        timer2_evt,
    input  wire logic        timer3_evt,
    input  wire logic        cipher_done_evt,
    input  wire logic        sleep_timer_evt,
    input  wire logic        wakeup_evt,
    input  wire logic [3:0]  uart0_cause_reg,
    input  wire logic [3:0]  uart1_cause_reg,
    input  wire logic        radio_req,
    input  wire logic        spi_local_irq_en,
    input  wire logic        spi_local_pending,
    input  wire logic [23:0] voice_sub_en,
    input  wire logic [23:0] voice_sub_pending,
    input  wire logic [21:0] gpio_pin_req,
    input  wire logic        pwm_req,
    input  wire logic        dma_done_req,
    input  wire logic        i2c_req,
    input  wire logic        infrared_tx_req,
    input  wire logic        cpu_irq_ack,
    input  wire logic        cpu_irq_return,
    output logic             irq_req,
    output logic      [15:0] irq_vector,
    output logic      [4:0]  irq_source,
    output logic             irq_level_high,
    output logic             in_service_low,
    output logic             in_service_high
);

    logic [7:0]  timer_control_reg_ff, nxt_timer_control_reg;
    logic [7:0]  ext_flags_a_ff,       nxt_ext_flags_a;
    logic [7:0]  ext_flags_b_ff,       nxt_ext_flags_b;
    logic [7:0]  base_en_ff,           nxt_base_en;
    logic [7:0]  ext_en_a_ff,          nxt_ext_en_a;
    logic [4:0]  ext_en_b_ff,          nxt_ext_en_b;
    logic [7:0]  base_lvl_ff,          nxt_base_lvl;
    logic [7:0]  ext_lvl_a_ff,         nxt_ext_lvl_a;
    logic [4:0]  ext_lvl_b_ff,         nxt_ext_lvl_b;
    logic [31:0] prdata_ff,            nxt_prdata;
    logic        pready_ff,            nxt_pready;
    logic        pslverr_ff,           nxt_pslverr;
    logic        irq_req_ff,           nxt_irq_req;
    logic [15:0] irq_vector_ff,        nxt_irq_vector;
    logic [4:0]  irq_source_ff,        nxt_irq_source;
    logic        irq_level_ff,         nxt_irq_level;
    logic        svc_low_ff,           nxt_svc_low;
    logic        svc_high_ff,          nxt_svc_high;

    logic [18:0] src_pending;
    logic [18:0] src_enable;
    logic [18:0] src_level;
    logic [18:0] eligible;
    logic [7:0]  wr_idx;
    logic        wr_en;
    logic        idx_ok;
    logic [7:0]  wb;
    logic [7:0]  rd_val;
    logic        found_hi;
    logic        found_lo;
    logic [4:0]  pick_hi;
    logic [4:0]  pick_lo;
    logic        ack_clear;

    assign wr_idx = paddr[9:2];
    assign wb     = pwdata[7:0];
    assign wr_en  = psel & penable & pready_ff & pwrite;
    assign ack_clear = cpu_irq_ack & irq_req_ff;

    // Flag, enable and level vectors indexed by fixed source number
    always_comb begin
        src_pending = {
            dma_done_req,                                            // 18
            pwm_req,                                                 // 17
            ~power_down & |(gpio_pin_req & ~cic_pkg::GPIO_EXT_MASK), // 16
            ext_flags_b_ff[cic_pkg::BIT_WAKEUP_PEND],                // 15
            |(voice_sub_en & voice_sub_pending),                     // 14
            spi_local_irq_en & spi_local_pending,                    // 13
            ext_flags_b_ff[cic_pkg::BIT_SLEEP_PEND],                 // 12
            ext_flags_a_ff[cic_pkg::BIT_TIMER3_PEND],                // 11
            ext_flags_a_ff[cic_pkg::BIT_CIPHER_PEND],                // 10
            ext_flags_a_ff[cic_pkg::BIT_TIMER2_PEND],                // 9
            radio_req,                                               // 8
            uart1_cause_reg[0],                                      // 7
            i2c_req,                                                 // 6
            infrared_tx_req,                                         // 5
            uart0_cause_reg[0],                                      // 4
            timer_control_reg_ff[cic_pkg::BIT_TIMER1_PEND],          // 3
            timer_control_reg_ff[cic_pkg::BIT_EXT_IN1_PEND],         // 2
            timer_control_reg_ff[cic_pkg::BIT_TIMER0_PEND],          // 1
            timer_control_reg_ff[cic_pkg::BIT_EXT_IN0_PEND]          // 0
        };
        src_enable = {ext_en_b_ff[4:2], ext_en_a_ff, base_en_ff[6],
                      ext_en_b_ff[1:0], base_en_ff[4:0]};
        src_level  = {ext_lvl_b_ff[4:2], ext_lvl_a_ff, base_lvl_ff[6],
                      ext_lvl_b_ff[1:0], base_lvl_ff[4:0]};
        // Live enables each cycle, so a late enable on a held flag requests
        eligible = src_pending & src_enable
                 & {19{base_en_ff[cic_pkg::BIT_GLOBAL_GATE]}};
    end

    // Scan downward so the lowest number wins within a level
    always_comb begin
        found_hi = 1'b0;
        found_lo = 1'b0;
        pick_hi  = 5'h00;
        pick_lo  = 5'h00;
        for (int i = cic_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (eligible[i] && src_level[i]) begin
                found_hi = 1'b1;
                pick_hi  = 5'(i);
            end
            if (eligible[i] && !src_level[i]) begin
                found_lo = 1'b1;
                pick_lo  = 5'(i);
            end
        end
    end

    always_comb begin
        rd_val = 8'h00;
        idx_ok = 1'b1;
        if (wr_idx == cic_pkg::IDX_TIMER_CTRL) begin
            rd_val = timer_control_reg_ff & 8'haa;
        end else if (wr_idx == cic_pkg::IDX_EXT_FLAGS_A) begin
            rd_val = ext_flags_a_ff;
        end else if (wr_idx == cic_pkg::IDX_BASE_EN) begin
            rd_val = base_en_ff;
        end else if (wr_idx == cic_pkg::IDX_BASE_LVL) begin
            rd_val = base_lvl_ff;
        end else if (wr_idx == cic_pkg::IDX_EXT_FLAGS_B) begin
            rd_val = ext_flags_b_ff;
        end else if (wr_idx == cic_pkg::IDX_EXT_EN_A) begin
            rd_val = ext_en_a_ff;
        end else if (wr_idx == cic_pkg::IDX_EXT_EN_B) begin
            rd_val = {3'h0, ext_en_b_ff};
        end else if (wr_idx == cic_pkg::IDX_EXT_LVL_A) begin
            rd_val = ext_lvl_a_ff;
        end else if (wr_idx == cic_pkg::IDX_EXT_LVL_B) begin
            rd_val = {3'h0, ext_lvl_b_ff};
        end else begin
            idx_ok = 1'b0;
        end
        if (paddr[11:10] != 2'h0 || paddr[1:0] != 2'h0) begin
            idx_ok = 1'b0;
        end
    end

    always_comb begin
        nxt_timer_control_reg = timer_control_reg_ff;
        nxt_ext_flags_a       = ext_flags_a_ff;
        nxt_ext_flags_b       = ext_flags_b_ff;
        nxt_base_en           = base_en_ff;
        nxt_ext_en_a          = ext_en_a_ff;
        nxt_ext_en_b          = ext_en_b_ff;
        nxt_base_lvl          = base_lvl_ff;
        nxt_ext_lvl_a         = ext_lvl_a_ff;
        nxt_ext_lvl_b         = ext_lvl_b_ff;
        nxt_pready            = psel & ~penable;
        nxt_prdata            = 32'h00000000;
        nxt_pslverr           = 1'b0;
        if (psel && !penable) begin
            nxt_prdata  = idx_ok ? {24'h000000, rd_val} : 32'h00000000;
            nxt_pslverr = ~idx_ok;
        end

        // Software writes first; hardware sets below override clears
        if (wr_en && idx_ok) begin
            if (wr_idx == cic_pkg::IDX_TIMER_CTRL) begin
                nxt_timer_control_reg = wb & 8'haa;
            end else if (wr_idx == cic_pkg::IDX_EXT_FLAGS_A) begin
                nxt_ext_flags_a = ext_flags_a_ff & ~(wb & 8'he0);
            end else if (wr_idx == cic_pkg::IDX_BASE_EN) begin
                nxt_base_en = wb & cic_pkg::MASK_BASE_EN;
            end else if (wr_idx == cic_pkg::IDX_BASE_LVL) begin
                nxt_base_lvl = wb & cic_pkg::MASK_BASE_LVL;
            end else if (wr_idx == cic_pkg::IDX_EXT_FLAGS_B) begin
                nxt_ext_flags_b = ext_flags_b_ff & ~(wb & 8'h03);
            end else if (wr_idx == cic_pkg::IDX_EXT_EN_A) begin
                nxt_ext_en_a = wb;
            end else if (wr_idx == cic_pkg::IDX_EXT_EN_B) begin
                nxt_ext_en_b = wb[4:0] & cic_pkg::MASK_EXT_B;
            end else if (wr_idx == cic_pkg::IDX_EXT_LVL_A) begin
                nxt_ext_lvl_a = wb;
            end else if (wr_idx == cic_pkg::IDX_EXT_LVL_B) begin
                nxt_ext_lvl_b = wb[4:0] & cic_pkg::MASK_EXT_B;
            end
        end

        // Grant auto-clears the external and timer 0/1 flags
        if (ack_clear) begin
            case (irq_source_ff)
                5'h00: nxt_timer_control_reg[cic_pkg::BIT_EXT_IN0_PEND] = 1'b0;
                5'h01: nxt_timer_control_reg[cic_pkg::BIT_TIMER0_PEND]  = 1'b0;
                5'h02: nxt_timer_control_reg[cic_pkg::BIT_EXT_IN1_PEND] = 1'b0;
                5'h03: nxt_timer_control_reg[cic_pkg::BIT_TIMER1_PEND]  = 1'b0;
                default: ;
            endcase
        end

        if (ext_in0_evt) nxt_timer_control_reg[cic_pkg::BIT_EXT_IN0_PEND] = 1'b1;
        if (ext_in1_evt) nxt_timer_control_reg[cic_pkg::BIT_EXT_IN1_PEND] = 1'b1;
        if (timer0_evt)  nxt_timer_control_reg[cic_pkg::BIT_TIMER0_PEND]  = 1'b1;
        if (timer1_evt)  nxt_timer_control_reg[cic_pkg::BIT_TIMER1_PEND]  = 1'b1;
        if (timer3_evt)      nxt_ext_flags_a[cic_pkg::BIT_TIMER3_PEND] = 1'b1;
        if (cipher_done_evt) nxt_ext_flags_a[cic_pkg::BIT_CIPHER_PEND] = 1'b1;
        if (timer2_evt)      nxt_ext_flags_a[cic_pkg::BIT_TIMER2_PEND] = 1'b1;
        // Sleep-timer flag only counts in normal mode
        if (sleep_timer_evt && !power_down) begin
            nxt_ext_flags_b[cic_pkg::BIT_SLEEP_PEND] = 1'b1;
        end
        // External inputs also wake the core from power-down
        if (wakeup_evt || (power_down && (ext_in0_evt || ext_in1_evt))) begin
            nxt_ext_flags_b[cic_pkg::BIT_WAKEUP_PEND] = 1'b1;
        end
    end

    // Request presentation and in-service tracking
    always_comb begin
        nxt_svc_low  = svc_low_ff;
        nxt_svc_high = svc_high_ff;
        if (ack_clear) begin
            if (irq_level_ff) begin
                nxt_svc_high = 1'b1;
            end else begin
                nxt_svc_low = 1'b1;
            end
        end else if (cpu_irq_return) begin
            // Return closes the innermost, i.e. high if active
            if (svc_high_ff) begin
                nxt_svc_high = 1'b0;
            end else begin
                nxt_svc_low = 1'b0;
            end
        end
        nxt_irq_req    = 1'b0;
        nxt_irq_source = 5'h00;
        nxt_irq_level  = 1'b0;
        // Drop request for one cycle after an ack so the flag clear settles
        if (!ack_clear) begin
            if (found_hi && !nxt_svc_high) begin
                nxt_irq_req    = 1'b1;
                nxt_irq_source = pick_hi;
                nxt_irq_level  = 1'b1;
            end else if (found_lo && !nxt_svc_high && !nxt_svc_low) begin
                nxt_irq_req    = 1'b1;
                nxt_irq_source = pick_lo;
            end
        end
        nxt_irq_vector = cic_pkg::VEC_BASE
                       + 16'(cic_pkg::VEC_STRIDE * {11'h000, nxt_irq_source});
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_control_reg_ff <= cic_pkg::RST_REG8;
            ext_flags_a_ff       <= cic_pkg::RST_REG8;
            ext_flags_b_ff       <= cic_pkg::RST_REG8;
            base_en_ff           <= cic_pkg::RST_REG8;
            ext_en_a_ff          <= cic_pkg::RST_REG8;
            ext_en_b_ff          <= cic_pkg::RST_REG5;
            base_lvl_ff          <= cic_pkg::RST_REG8;
            ext_lvl_a_ff         <= cic_pkg::RST_REG8;
            ext_lvl_b_ff         <= cic_pkg::RST_REG5;
            prdata_ff            <= 32'h00000000;
            pready_ff            <= 1'b0;
            pslverr_ff           <= 1'b0;
            irq_req_ff           <= 1'b0;
            irq_vector_ff        <= cic_pkg::VEC_BASE;
            irq_source_ff        <= 5'h00;
            irq_level_ff         <= 1'b0;
            svc_low_ff           <= 1'b0;
            svc_high_ff          <= 1'b0;
        end else begin
            timer_control_reg_ff <= nxt_timer_control_reg;
            ext_flags_a_ff       <= nxt_ext_flags_a;
            ext_flags_b_ff       <= nxt_ext_flags_b;
            base_en_ff           <= nxt_base_en;
            ext_en_a_ff          <= nxt_ext_en_a;
            ext_en_b_ff          <= nxt_ext_en_b;
            base_lvl_ff          <= nxt_base_lvl;
            ext_lvl_a_ff         <= nxt_ext_lvl_a;
            ext_lvl_b_ff         <= nxt_ext_lvl_b;
            prdata_ff            <= nxt_prdata;
            pready_ff            <= nxt_pready;
            pslverr_ff           <= nxt_pslverr;
            irq_req_ff           <= nxt_irq_req;
            irq_vector_ff        <= nxt_irq_vector;
            irq_source_ff        <= nxt_irq_source;
            irq_level_ff         <= nxt_irq_level;
            svc_low_ff           <= nxt_svc_low;
            svc_high_ff          <= nxt_svc_high;
        end
    end

    assign prdata          = prdata_ff;
    assign pready          = pready_ff;
    assign pslverr         = pslverr_ff;
    assign irq_req         = irq_req_ff;
    assign irq_vector      = irq_vector_ff;
    assign irq_source      = irq_source_ff;
    assign irq_level_high  = irq_level_ff;
    assign in_service_low  = svc_low_ff;
    assign in_service_high = svc_high_ff;

endmodule : cic_ctrl

`default_nettype wire

// ### testbench/cic_props.sv
`timescale 1ns/1ps
`default_nettype none
module cic_props (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        cpu_irq_ack,
    input wire logic        cpu_irq_return,
    input wire logic        irq_req,
    input wire logic [15:0] irq_vector,
    input wire logic [4:0]  irq_source,
    input wire logic        irq_level_high,
    input wire logic        in_service_low,
    input wire logic        in_service_high
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_grant;
        irq_req && cpu_irq_ack;
    endsequence
    a_vec_map: assert property (irq_req |-> irq_vector == 16'h0003 + {8'h00, irq_source, 3'h0})
        else $error("vector does not match source");
    a_src_range: assert property (irq_req |-> irq_source <= 5'h12)
        else $error("source number out of range");
    a_grant_drop: assert property (s_grant |=> !irq_req)
        else $error("request stays after grant");
    a_grant_svc: assert property (s_grant ##0 !irq_level_high |=> in_service_low)
        else $error("low grant not in service");
    a_high_hold: assert property (in_service_high |-> !irq_req)
        else $error("request during high service");
    a_low_preempt: assert property (in_service_low && irq_req |-> irq_level_high)
        else $error("low request during low service");
    a_ret_pop: assert property (cpu_irq_return && !cpu_irq_ack && in_service_low && !in_service_high
        |=> !in_service_low)
        else $error("return did not end service");
    a_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("ready not one access cycle");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
endmodule : cic_props
bind cic_ctrl cic_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .cpu_irq_ack(cpu_irq_ack), .cpu_irq_return(cpu_irq_return),
    .irq_req(irq_req), .irq_vector(irq_vector), .irq_source(irq_source), .irq_level_high(irq_level_high),
    .in_service_low(in_service_low), .in_service_high(in_service_high));
`default_nettype wire

// ### testbench/cic_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module cic_cpu_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       irq_req,
    input  wire logic       auto_on,
    input  wire logic [3:0] ack_dly,
    input  wire logic [3:0] svc_len,
    output logic            cpu_irq_ack,
    output logic            cpu_irq_return
);
    logic [3:0] wait_ff;
    logic [3:0] t_ff;
    logic [1:0] depth_ff;
    logic       fin;
    assign fin = (depth_ff != 2'h0) && (t_ff == svc_len);
    // Never ack in a return cycle: the controller would lose the return
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_ff <= 4'h0;
            t_ff <= 4'h0;
            depth_ff <= 2'h0;
            cpu_irq_ack <= 1'b0;
            cpu_irq_return <= 1'b0;
        end else begin
            cpu_irq_ack <= 1'b0;
            cpu_irq_return <= 1'b0;
            wait_ff <= 4'h0;
            if (auto_on && irq_req && !cpu_irq_ack && !fin) begin
                if (wait_ff == ack_dly) cpu_irq_ack <= 1'b1;
                else wait_ff <= wait_ff + 4'h1;
            end
            if (cpu_irq_ack) begin
                depth_ff <= depth_ff + 2'h1;
                t_ff <= 4'h0;
            end else if (fin) begin
                cpu_irq_return <= 1'b1;
                depth_ff <= depth_ff - 2'h1;
                t_ff <= 4'h0;
            end else if (depth_ff != 2'h0) begin
                t_ff <= t_ff + 4'h1;
            end
        end
    end
endmodule : cic_cpu_model
`default_nettype wire

// ### testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic        ack, ret, irq_req, lvl_h, isl, ish, auto_on, g18, pd;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [15:0] irq_vector;
    logic [4:0]  irq_source;
    logic [8:0]  ev;
    logic [18:0] lv;
    logic [3:0]  dly;
    int          n_fail, cmp_count;
    logic [4:0]  grants[$];
    int          lvl_src[10] = '{4, 5, 6, 7, 8, 13, 14, 16, 17, 18};
    logic [7:0]  regs[5] = '{cic_pkg::IDX_EXT_FLAGS_A, cic_pkg::IDX_BASE_EN, cic_pkg::IDX_EXT_FLAGS_B,
                             cic_pkg::IDX_EXT_EN_A, cic_pkg::IDX_EXT_EN_B};

    cic_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .power_down(pd), .ext_in0_evt(ev[0]), .timer0_evt(ev[1]), .ext_in1_evt(ev[2]),
        .timer1_evt(ev[3]), .timer2_evt(ev[4]), .cipher_done_evt(ev[5]), .timer3_evt(ev[6]),
        .sleep_timer_evt(ev[7]), .wakeup_evt(ev[8]), .uart0_cause_reg({3'h2, lv[4]}),
        .uart1_cause_reg({3'h1, lv[7]}), .radio_req(lv[8]), .spi_local_irq_en(lv[13]),
        .spi_local_pending(lv[13]), .voice_sub_en({24{lv[14]}}), .voice_sub_pending({15'h0, lv[14], 8'h00}),
        .gpio_pin_req({3'h0, g18, 14'h0, lv[16], 3'h0}), .pwm_req(lv[17]), .dma_done_req(lv[18]),
        .i2c_req(lv[6]), .infrared_tx_req(lv[5]), .cpu_irq_ack(ack), .cpu_irq_return(ret),
        .irq_req(irq_req), .irq_vector(irq_vector), .irq_source(irq_source), .irq_level_high(lvl_h),
        .in_service_low(isl), .in_service_high(ish));
    cic_cpu_model cpu (.pclk(pclk), .presetn(presetn), .irq_req(irq_req), .auto_on(auto_on),
        .ack_dly(dly), .svc_len(4'ha), .cpu_irq_ack(ack), .cpu_irq_return(ret));

    always #25 pclk = ~pclk;
    always @(posedge pclk) if (ack && irq_req) grants.push_back(irq_source);

    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task rd(input logic [7:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 32'h0);
        chk("read data", q, {24'h0, exp});
    endtask : rd
    task tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick
    task pulse(input logic [8:0] m);
        @(posedge pclk);
        ev <= m;
        @(posedge pclk);
        ev <= 9'h0;
    endtask : pulse
    task wait_req;
        for (int i = 0; i < 20 && irq_req !== 1'b1; i++) @(posedge pclk);
    endtask : wait_req
    task report_and_stop;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop

    initial begin
        pclk = 0;
        presetn = 0;
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = 0;
        pwdata = 0;
        ev = 0;
        lv = 0;
        g18 = 0;
        pd = 0;
        auto_on = 0;
        dly = 0;
        n_fail = 0;
        cmp_count = 0;
        tick(4);
        presetn <= 1'b1;
        foreach (regs[i]) rd(regs[i], 8'h00);
        apb(1'b1, regs[1], 32'hff);
        rd(regs[1], 8'hdf);
        apb(1'b1, regs[3], 32'hff);
        rd(regs[3], 8'hff);
        apb(1'b1, regs[4], 32'hff);
        rd(regs[4], 8'h1f);
        apb(1'b0, 8'h00, 32'h0);
        chk("unmapped error", e, 1);
        chk("unmapped read", q, 0);
        g18 <= 1'b1;
        tick(4);
        chk("ext pin on gpio", irq_req, 0);
        g18 <= 1'b0;
        foreach (lvl_src[i]) begin
            lv[lvl_src[i]] <= 1'b1;
            tick(1);
            wait_req;
            chk("source", irq_source, lvl_src[i]);
            chk("vector", irq_vector, 3 + 8 * lvl_src[i]);
            lv <= 19'h0;
            tick(3);
        end
        pulse(9'h1f0);
        rd(regs[0], 8'he0);
        rd(regs[2], 8'h03);
        apb(1'b1, regs[0], 32'h20);
        rd(regs[0], 8'hc0);
        apb(1'b1, regs[0], 32'hc0);
        apb(1'b1, regs[2], 32'h03);
        rd(regs[0], 8'h00);
        rd(regs[2], 8'h00);
        apb(1'b1, regs[1], 32'h02);
        pulse(9'h002);
        tick(4);
        chk("gate off request", irq_req, 0);
        apb(1'b1, regs[1], 32'h82);
        rd(cic_pkg::IDX_TIMER_CTRL, 8'h20);
        chk("late enable source", irq_source, 1);
        auto_on <= 1'b1;
        tick(4);
        rd(cic_pkg::IDX_TIMER_CTRL, 8'h00);
        tick(20);
        grants.delete();
        dly <= 4'h3;
        apb(1'b1, regs[1], 32'h8f);
        pulse(9'h00f);
        tick(90);
        for (int i = 0; i < 4; i++) chk("grant order", grants[i], i);
        grants.delete();
        dly <= 4'h0;
        apb(1'b1, cic_pkg::IDX_BASE_LVL, 32'h02);
        pulse(9'h001);
        tick(4);
        chk("low in service", isl, 1);
        pulse(9'h002);
        tick(4);
        chk("high in service", ish, 1);
        tick(36);
        chk("low first", grants[0], 0);
        chk("high preempts", grants[1], 1);
        // Power-down: external input wakes, sleep timeout is ignored
        pd <= 1'b1;
        pulse(9'h081);
        pd <= 1'b0;
        rd(regs[2], 8'h01);
        report_and_stop;
    end
    // Whole run is under a thousand cycles
    initial begin
        repeat (5000) @(posedge pclk);
        n_fail++;
        report_and_stop;
    end
endmodule : tb_top
`default_nettype wire
